// ### hw/fsf_defs.svh
// offsets, field positions, reset values and counts of the fault flags
`ifndef FSF_DEFS_SVH
`define FSF_DEFS_SVH

// ==========================================================
// register offsets
`define FSF_ADDR_STATUS_TWO    8'h42
`define FSF_ADDR_STATUS_THREE  8'h43

// ==========================================================
// fault_status_two field positions
`define FSF_S2_V12             0
`define FSF_S2_SUMMARY         1
`define FSF_S2_FAN_BASE        2
`define FSF_S2_DIODE_ONE       6
`define FSF_S2_DIODE_TWO       7

// ==========================================================
// fault_status_three field positions
`define FSF_S3_ZONE_FOUR       0
`define FSF_S3_PECI_DATA       1
`define FSF_S3_PECI_LINK       2
`define FSF_S3_ABS_LIMIT       3
`define FSF_S3_USED_BITS       4

// ==========================================================
// reset values and counts
`define FSF_FLAG_RESET         1'b0
`define FSF_STATUS_RESET       8'h00
`define FSF_FAN_COUNT          4
`define FSF_PECI_COUNT         4

`endif

// ### hw/fsf_pkg.sv
// shared types of the fault status flag block
package fsf_pkg;

  // ==========================================================
  // data types
  typedef logic [7:0]  fsf_byte_t;
  typedef logic [15:0] fsf_count_t;
  typedef logic [3:0]  fsf_nibble_t;

endpackage

// ### hw/fsf_sticky_bit.sv
// one sticky fault flag: set by its condition, cleared by a read
`timescale 1ns/100ps
`include "fsf_defs.svh"

module fsf_sticky_bit
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // control
  input  wire logic fault,
  input  wire logic clear,
  // state
  output logic      flag_q
);

  logic flag_d;

  // ==========================================================
  // next value: a present fault always wins over the clear
  always_comb
  begin
    flag_d = fault | (flag_q & ~clear);
  end

  // register
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      flag_q <= `FSF_FLAG_RESET;
    else
      flag_q <= flag_d;
  end

endmodule

// ### hw/fsf_status.sv
// sticky fault status registers two and three with read-to-clear
// Notes on behaviour
// - read-only byte at 42h: 12V, summary, four fan stalls, two diode faults.
// - a flag sets on its fault and holds until software reads it.
// - a read clears each flag only if its fault has gone.
// - writes to either status register change nothing.
// - 12V flag sets when value <= low limit or > high limit.
// - summary bit 1 of 42h sets while any 43h bit is set.
// - fan stall flag sets when tach period exceeds its 16-bit minimum.
// - remote diode one open sets bit 6 and the zone one flag.
// - remote diode two open sets bit 7 and the zone three flag.
// - read-only byte at 43h: zone four, PECI data, link, absolute; rest zero.
// - zone four flag sets while its temperature limit is exceeded.
// - PECI data flag sets when any processor reports error and underflow.
// - PECI link flag sets when any processor reports error without underflow.
// - absolute limit flag sets when any zone passes its absolute limit.
// - first status register bit 7 sets while any 42h bit is set.
`timescale 1ns/100ps
`include "fsf_defs.svh"

module fsf_status
(
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  // register access from the serial bus engine
  input  wire logic [7:0]                  reg_addr,
  input  wire logic                        reg_rd,
  input  wire logic                        reg_wr,
  input  wire logic [7:0]                  reg_wdata,
  output fsf_pkg::fsf_byte_t               reg_rdata_q,
  // 12V measurement and limits
  input  wire logic [7:0]                  v12_value,
  input  wire logic [7:0]                  v12_low_limit,
  input  wire logic [7:0]                  v12_high_limit,
  // fan tachometer periods and minimum counts
  input  wire logic [3:0][15:0]            tach_period,
  input  wire logic [3:0][15:0]            tach_minimum,
  // remote diode open faults
  input  wire logic                        remote_diode_one_open,
  input  wire logic                        remote_diode_two_open,
  // temperature zones
  input  wire logic                        zone_four_exceeded,
  input  wire logic                        any_zone_abs_exceeded,
  // per-processor PECI status
  input  wire logic [3:0]                  peci_error,
  input  wire logic [3:0]                  peci_underflow,
  // to the first status register
  output logic                             status_two_any_q,
  output logic                             zone_one_fault_q,
  output logic                             zone_three_fault_q
);

  fsf_pkg::fsf_byte_t   stat2_q;
  fsf_pkg::fsf_nibble_t stat3_q;
  fsf_pkg::fsf_byte_t   cond2;
  fsf_pkg::fsf_nibble_t cond3;
  logic                 rd_two;
  logic                 rd_three;
  fsf_pkg::fsf_byte_t   reg_rdata_d;
  logic                 status_two_any_d;
  logic                 zone_one_fault_d;
  logic                 zone_three_fault_d;
  logic [3:0]           fan_stall;

  // ==========================================================
  // read decode; writes are never decoded
  assign rd_two   = reg_rd && (reg_addr == `FSF_ADDR_STATUS_TWO);
  assign rd_three = reg_rd && (reg_addr == `FSF_ADDR_STATUS_THREE);

  // ==========================================================
  // per-fan stall comparison
  genvar g;
  generate
    for (g = 0; g < `FSF_FAN_COUNT; g++)
    begin : g_fan
      assign fan_stall[g] = tach_period[g] > tach_minimum[g];
    end
  endgenerate

  // ==========================================================
  // fault conditions for both registers
  always_comb
  begin
    cond2 = 8'h00;
    cond3 = 4'h0;
    cond2[`FSF_S2_V12] = (v12_value <= v12_low_limit)
                       | (v12_value > v12_high_limit);
    cond2[`FSF_S2_SUMMARY] = |stat3_q;
    cond2[`FSF_S2_FAN_BASE +: 4] = fan_stall;
    cond2[`FSF_S2_DIODE_ONE] = remote_diode_one_open;
    cond2[`FSF_S2_DIODE_TWO] = remote_diode_two_open;
    cond3[`FSF_S3_ZONE_FOUR] = zone_four_exceeded;
    cond3[`FSF_S3_PECI_DATA] = |(peci_error & peci_underflow);
    cond3[`FSF_S3_PECI_LINK] = |(peci_error & ~peci_underflow);
    cond3[`FSF_S3_ABS_LIMIT] = any_zone_abs_exceeded;
  end

  // ==========================================================
  // sticky flags, one per bit
  generate
    for (g = 0; g < 8; g++)
    begin : g_two
      fsf_sticky_bit u_bit
      (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .fault   (cond2[g]),
        .clear   (rd_two),
        .flag_q  (stat2_q[g])
      );
    end
    for (g = 0; g < `FSF_S3_USED_BITS; g++)
    begin : g_three
      fsf_sticky_bit u_bit
      (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .fault   (cond3[g]),
        .clear   (rd_three),
        .flag_q  (stat3_q[g])
      );
    end
  endgenerate

  // ==========================================================
  // read data and outputs toward the first status register
  always_comb
  begin
    reg_rdata_d = reg_rdata_q;
    if (rd_two)
      reg_rdata_d = stat2_q;
    else if (rd_three)
      reg_rdata_d = {4'h0, stat3_q};
    else if (reg_rd)
      reg_rdata_d = `FSF_STATUS_RESET;
    status_two_any_d   = |stat2_q;
    zone_one_fault_d   = remote_diode_one_open;
    zone_three_fault_d = remote_diode_two_open;
  end

  // register
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      reg_rdata_q        <= `FSF_STATUS_RESET;
      status_two_any_q   <= 1'b0;
      zone_one_fault_q   <= 1'b0;
      zone_three_fault_q <= 1'b0;
    end
    else
    begin
      reg_rdata_q        <= reg_rdata_d;
      status_two_any_q   <= status_two_any_d;
      zone_one_fault_q   <= zone_one_fault_d;
      zone_three_fault_q <= zone_three_fault_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_rd_two;
    rd_two;
  endsequence

  sequence s_gone_two;
    cond2 == 8'h00;
  endsequence

  a_read_two_data:
    assert property (s_rd_two |=> reg_rdata_q == $past(stat2_q))
    else $error("status two read data wrong");

  a_hold_until_read:
    assert property (!rd_two |=> (stat2_q & $past(stat2_q))
                                 == $past(stat2_q))
    else $error("status two flag lost without read");

  a_read_clears:
    assert property (s_rd_two ##0 s_gone_two |=> stat2_q == 8'h00)
    else $error("status two not cleared after read");

  a_write_ignored:
    assert property (reg_wr && !reg_rd |=> (stat3_q & $past(stat3_q))
                                           == $past(stat3_q))
    else $error("write altered status three");

  a_v12_window:
    assert property ((v12_value <= v12_low_limit)
                     || (v12_value > v12_high_limit)
                     |=> stat2_q[`FSF_S2_V12])
    else $error("12V flag not set");

  a_summary_three:
    assert property ((|stat3_q) |=> stat2_q[`FSF_S2_SUMMARY])
    else $error("summary of status three missing");

  a_fan_one_stall:
    assert property (tach_period[0] > tach_minimum[0]
                     |=> stat2_q[`FSF_S2_FAN_BASE])
    else $error("fan one stall flag not set");

  a_diode_one_open:
    assert property (remote_diode_one_open
                     |=> stat2_q[`FSF_S2_DIODE_ONE] && zone_one_fault_q)
    else $error("diode one fault not flagged");

  a_diode_two_open:
    assert property (remote_diode_two_open
                     |=> stat2_q[`FSF_S2_DIODE_TWO] && zone_three_fault_q)
    else $error("diode two fault not flagged");

  a_reserved_zero:
    assert property (rd_three |=> reg_rdata_q[7:4] == 4'h0
                                  && reg_rdata_q[3:0] == $past(stat3_q))
    else $error("status three read wrong");

  a_zone_four_set:
    assert property (zone_four_exceeded |=> stat3_q[`FSF_S3_ZONE_FOUR])
    else $error("zone four flag not set");

  a_peci_data_set:
    assert property (|(peci_error & peci_underflow)
                     |=> stat3_q[`FSF_S3_PECI_DATA])
    else $error("PECI data flag not set");

  a_peci_link_set:
    assert property (|(peci_error & ~peci_underflow)
                     |=> stat3_q[`FSF_S3_PECI_LINK])
    else $error("PECI link flag not set");

  a_abs_limit_set:
    assert property (any_zone_abs_exceeded |=> stat3_q[`FSF_S3_ABS_LIMIT])
    else $error("absolute limit flag not set");

  a_chain_summary:
    assert property ((|stat2_q) |=> status_two_any_q)
    else $error("status two summary output missing");

  a_reset_clear:
    assert property (@(posedge sys_clk) disable iff (1'b0)
                     !resetn |=> stat2_q == 8'h00 && stat3_q == 4'h0)
    else $error("flags not cleared by reset");

endmodule

// ### sim/fsf_host_model.sv
// host side model issuing single-byte register reads and writes
`timescale 1ns/100ps

module fsf_host_model
(
  // clock
  input  wire logic       sys_clk,
  // register access to the status block
  output logic [7:0]      reg_addr,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata_q
);
  // idle bus at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
  end

  // one read strobe; data taken once the answering edge has landed
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~addr;  // released address never shows the old one
    #1;
    data = reg_rdata_q;
  endtask

  // one write strobe; the block must ignore it
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~addr;
    reg_wdata <= ~data;
  endtask
endmodule

// ### sim/fault_status_flags_two_three_test.sv
// self-checking bench of the sticky fault status registers
`timescale 1ns/100ps
`include "fsf_defs.svh"

module fault_status_flags_two_three_test;
  // ==========================================================
  // stimulus and observed signals
  logic               sys_clk = 1'b0;
  logic               resetn  = 1'b0;
  logic [7:0]         reg_addr;
  logic               reg_rd;
  logic               reg_wr;
  logic [7:0]         reg_wdata;
  fsf_pkg::fsf_byte_t reg_rdata_q;
  logic [7:0]         v12_value      = 8'h80;
  logic [7:0]         v12_low_limit  = 8'h40;
  logic [7:0]         v12_high_limit = 8'hC0;
  logic [3:0][15:0]   tach_period    = {4{16'h0000}};
  logic [3:0][15:0]   tach_minimum   = {4{16'h1000}};
  logic               remote_diode_one_open = 1'b0;
  logic               remote_diode_two_open = 1'b0;
  logic               zone_four_exceeded    = 1'b0;
  logic               any_zone_abs_exceeded = 1'b0;
  logic [3:0]         peci_error     = 4'h0;
  logic [3:0]         peci_underflow = 4'h0;
  logic               two_any;
  logic               zone_one;
  logic               zone_three;
  int                 fail_count = 0;
  int                 n_tests    = 0;
  // {zone four, absolute, peci error, peci underflow} and expected 43h
  // packed tables, entry 0 at the right
  localparam logic [4:0][9:0] C3 = {10'h00F, 10'h100, 10'h084, 10'h011,
                                    10'h200};
  localparam logic [4:0][7:0] E3 = {8'h00, 8'h08, 8'h04, 8'h02, 8'h01};
  localparam logic [3:0][7:0] VV = {8'hC1, 8'hC0, 8'h41, 8'h40};
  localparam logic [3:0][7:0] VE = {8'h01, 8'h00, 8'h00, 8'h01};

  // ==========================================================
  // clock, design and host model
  always #5 sys_clk = ~sys_clk;

  fsf_status dut
  (
    .sys_clk, .resetn, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata_q, .v12_value, .v12_low_limit, .v12_high_limit,
    .tach_period, .tach_minimum, .remote_diode_one_open,
    .remote_diode_two_open, .zone_four_exceeded, .any_zone_abs_exceeded,
    .peci_error, .peci_underflow, .status_two_any_q(two_any),
    .zone_one_fault_q(zone_one), .zone_three_fault_q(zone_three)
  );

  fsf_host_model u_host
  (
    .sys_clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata_q
  );

  // ==========================================================
  // compare, read-and-compare and verdict
  task automatic chk(input fsf_pkg::fsf_byte_t seen,
                     input fsf_pkg::fsf_byte_t exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr,
                        input fsf_pkg::fsf_byte_t exp);
    fsf_pkg::fsf_byte_t d;
    u_host.rd(addr, d);
    chk(d, exp);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog against a hung sequence
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    // reset values and an unmapped address
    rd_chk(`FSF_ADDR_STATUS_TWO, `FSF_STATUS_RESET);
    rd_chk(`FSF_ADDR_STATUS_THREE, `FSF_STATUS_RESET);
    rd_chk(8'h44, 8'h00);
    // fan stall at and just above the minimum, every fan
    for (int n = 0; n < 4; n++)
      for (int k = 0; k < 2; k++)
      begin
        @(posedge sys_clk);
        tach_period[n] <= 16'h1000 + 16'(k);
        @(posedge sys_clk);
        tach_period[n] <= 16'h0000;
        rd_chk(8'h42, 8'((k << (n + 2))));
        rd_chk(8'h42, 8'h00);
      end
    // writes change nothing, a set flag survives them
    @(posedge sys_clk);
    tach_period[0] <= 16'hFFFF;
    @(posedge sys_clk);
    tach_period[0] <= 16'h0000;
    u_host.wr(8'h42, 8'h00);
    u_host.wr(8'h43, 8'hFF);
    rd_chk(8'h43, 8'h00);
    rd_chk(8'h42, 8'h04);
    rd_chk(8'h44, 8'h00);
    // 12V window edges, sticky after the level drops
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      v12_value <= VV[i];
      @(posedge sys_clk);
      v12_value <= 8'h80;
      repeat (3) @(posedge sys_clk);
      rd_chk(8'h42, VE[i]);
      rd_chk(8'h42, 8'h00);
    end
    // diode faults held through reads, then dropped
    for (int i = 0; i < 2; i++)
    begin
      @(posedge sys_clk);
      {remote_diode_two_open, remote_diode_one_open} <= 2'(1 << i);
      repeat (2) @(posedge sys_clk);
      #1;
      chk({6'h00, zone_three, zone_one}, 8'(1 << i));
      rd_chk(8'h42, 8'(8'h40 << i));
      rd_chk(8'h42, 8'(8'h40 << i));
      @(posedge sys_clk);
      {remote_diode_two_open, remote_diode_one_open} <= 2'b00;
      rd_chk(8'h42, 8'(8'h40 << i));
      rd_chk(8'h42, 8'h00);
    end
    // third register sources and the summary chain
    for (int i = 0; i < 5; i++)
    begin
      @(posedge sys_clk);
      {zone_four_exceeded, any_zone_abs_exceeded} <= C3[i][9:8];
      {peci_error, peci_underflow} <= C3[i][7:0];
      @(posedge sys_clk);
      {zone_four_exceeded, any_zone_abs_exceeded} <= 2'b00;
      {peci_error, peci_underflow} <= 8'h00;
      repeat (2) @(posedge sys_clk);
      #1;
      chk({7'h00, two_any}, {7'h00, E3[i] != 8'h00});
      rd_chk(8'h43, E3[i]);
      rd_chk(8'h43, 8'h00);
      rd_chk(8'h42, {6'h00, E3[i] != 8'h00, 1'b0});
      rd_chk(8'h42, 8'h00);
    end
    // a reset in mid-run clears flags that are still set
    @(posedge sys_clk);
    remote_diode_one_open <= 1'b1;
    zone_four_exceeded    <= 1'b1;
    @(posedge sys_clk);
    remote_diode_one_open <= 1'b0;
    zone_four_exceeded    <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk({7'h00, two_any}, 8'h01);
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd_chk(8'h42, 8'h00);
    rd_chk(8'h43, 8'h00);
    chk({5'h00, two_any, zone_three, zone_one}, 8'h00);
    give_verdict();
  end
endmodule
